// ==== hdl/pcpm_port_c.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcpm_port_c #(
    parameter int unsigned PINS = pcpm_pkg::PIN_COUNT
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [pcpm_pkg::ADDR_WIDTH-1:0] reg_addr,
    input wire logic [pcpm_pkg::REG_WIDTH-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [pcpm_pkg::REG_WIDTH-1:0] reg_rdata,
    input wire logic [PINS-1:0] port_out_value,
    output logic [PINS-1:0] port_in_value,
    input wire pcpm_pkg::pcpm_emac_out_s emac_out,
    output pcpm_pkg::pcpm_emac_in_s emac_in,
    input wire logic [PINS-1:0] pad_in,
    output logic [PINS-1:0] pad_out,
    output logic [PINS-1:0] pad_oe
);

    logic [15:0] dir_high_reg;
    logic [15:0] dir_low_reg;
    logic [15:0] func_high_reg;
    logic [15:0] func_low_upper_reg;
    logic [PINS-1:0] pad_meta_reg;
    logic [PINS-1:0] pad_sync_reg;
    logic [PINS-1:0] periph_sel;
    logic [PINS-1:0] direction;
    pcpm_pkg::pcpm_pad_drive_s drive_next;

    function automatic logic [15:0] masked_write(input logic [15:0] data,
                                                 input logic [15:0] mask);
        masked_write = data & mask;
    endfunction

    // reserved bits are never stored, so reads of them always give 0
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dir_high_reg <= pcpm_pkg::RST_DIR_HIGH;
            dir_low_reg <= pcpm_pkg::RST_DIR_LOW;
        end else if (reg_write) begin
            if (reg_addr == pcpm_pkg::OFS_DIR_HIGH) begin
                dir_high_reg <= masked_write(reg_wdata, pcpm_pkg::MASK_DIR_HIGH);
            end
            if (reg_addr == pcpm_pkg::OFS_DIR_LOW) begin
                dir_low_reg <= masked_write(reg_wdata, pcpm_pkg::MASK_DIR_LOW);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            func_high_reg <= pcpm_pkg::RST_FUNC_HIGH;
            func_low_upper_reg <= pcpm_pkg::RST_FUNC_LOW_UPPER;
        end else if (reg_write) begin
            if (reg_addr == pcpm_pkg::OFS_FUNC_HIGH) begin
                func_high_reg <= masked_write(reg_wdata, pcpm_pkg::MASK_FUNC_HIGH);
            end
            if (reg_addr == pcpm_pkg::OFS_FUNC_LOW_UPPER) begin
                func_low_upper_reg <=
                    masked_write(reg_wdata, pcpm_pkg::MASK_FUNC_LOW_UPPER);
            end
        end
    end

    // read data only in the cycle after the strobe; unmapped reads give 0
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            case (reg_addr)
                pcpm_pkg::OFS_DIR_HIGH: begin
                    reg_rdata <= dir_high_reg;
                end
                pcpm_pkg::OFS_DIR_LOW: begin
                    reg_rdata <= dir_low_reg;
                end
                pcpm_pkg::OFS_FUNC_HIGH: begin
                    reg_rdata <= func_high_reg;
                end
                pcpm_pkg::OFS_FUNC_LOW_UPPER: begin
                    reg_rdata <= func_low_upper_reg;
                end
                default: begin
                    reg_rdata <= 16'h0000;
                end
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // pad levels are asynchronous to sys_clk
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pad_meta_reg <= '0;
            pad_sync_reg <= '0;
        end else begin
            pad_meta_reg <= pad_in;
            pad_sync_reg <= pad_meta_reg;
        end
    end

    always_comb begin
        direction = {dir_high_reg[pcpm_pkg::DIR_HIGH_PINS-1:0], dir_low_reg};
        periph_sel = '0;
        periph_sel[20] = func_high_reg[pcpm_pkg::POS_PIN20_FUNC];
        periph_sel[19] = func_high_reg[pcpm_pkg::POS_PIN19_FUNC];
        periph_sel[18] = func_high_reg[pcpm_pkg::POS_PIN18_FUNC];
        periph_sel[17] = func_high_reg[pcpm_pkg::POS_PIN17_FUNC];
        periph_sel[16] = func_high_reg[pcpm_pkg::POS_PIN16_FUNC];
        periph_sel[15] = func_low_upper_reg[pcpm_pkg::POS_PIN15_FUNC];
        periph_sel[14] = func_low_upper_reg[pcpm_pkg::POS_PIN14_FUNC];
        periph_sel[13] = func_low_upper_reg[pcpm_pkg::POS_PIN13_FUNC];
        periph_sel[12] = func_low_upper_reg[pcpm_pkg::POS_PIN12_FUNC];
    end

    always_comb begin
        drive_next.value = port_out_value;
        drive_next.oe = direction;
        // a selected peripheral overrides the direction bit entirely
        if (periph_sel[20]) begin
            drive_next.value[20] = emac_out.wake_on_lan_output;
            drive_next.oe[20] = 1'b1;
        end
        if (periph_sel[19]) begin
            drive_next.value[19] = emac_out.external_output;
            drive_next.oe[19] = 1'b1;
        end
        if (periph_sel[18]) begin
            drive_next.value[18] = 1'b0;
            drive_next.oe[18] = 1'b0;
        end
        if (periph_sel[17]) begin
            drive_next.value[17] = emac_out.mdc;
            drive_next.oe[17] = 1'b1;
        end
        if (periph_sel[16]) begin
            drive_next.value[16] = emac_out.mdio_out;
            drive_next.oe[16] = emac_out.mdio_oe;
        end
        if (periph_sel[15]) begin
            drive_next.value[15] = 1'b0;
            drive_next.oe[15] = 1'b0;
        end
        if (periph_sel[14]) begin
            drive_next.value[14] = 1'b0;
            drive_next.oe[14] = 1'b0;
        end
        if (periph_sel[13]) begin
            drive_next.value[13] = 1'b0;
            drive_next.oe[13] = 1'b0;
        end
        if (periph_sel[12]) begin
            drive_next.value[12] = emac_out.tx_en;
            drive_next.oe[12] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pad_out <= '0;
            pad_oe <= '0;
        end else begin
            pad_out <= drive_next.value;
            pad_oe <= drive_next.oe;
        end
    end

    // controller inputs see 0 while their pin is a general port
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            emac_in <= '0;
            port_in_value <= '0;
        end else begin
            emac_in.link_status_input <= periph_sel[18] & pad_sync_reg[18];
            emac_in.mdio_in <= periph_sel[16] & pad_sync_reg[16];
            emac_in.crs <= periph_sel[15] & pad_sync_reg[15];
            emac_in.col <= periph_sel[14] & pad_sync_reg[14];
            emac_in.tx_clk <= periph_sel[13] & pad_sync_reg[13];
            port_in_value <= pad_sync_reg;
        end
    end

endmodule
`default_nettype wire

// ==== include/pcpm_pkg.sv ====
package pcpm_pkg;

    localparam int unsigned PIN_COUNT = 21;
    localparam int unsigned REG_WIDTH = 16;
    localparam int unsigned ADDR_WIDTH = 4;

    // register byte addresses
    localparam logic [3:0] OFS_DIR_HIGH = 4'h0;
    localparam logic [3:0] OFS_DIR_LOW = 4'h2;
    localparam logic [3:0] OFS_FUNC_HIGH = 4'h4;
    localparam logic [3:0] OFS_FUNC_LOW_UPPER = 4'h6;

    // reset values
    localparam logic [15:0] RST_DIR_HIGH = 16'h0000;
    localparam logic [15:0] RST_DIR_LOW = 16'h0000;
    localparam logic [15:0] RST_FUNC_HIGH = 16'h0000;
    localparam logic [15:0] RST_FUNC_LOW_UPPER = 16'h0000;

    // implemented (non-reserved) bits
    localparam logic [15:0] MASK_DIR_HIGH = 16'h001F;
    localparam logic [15:0] MASK_DIR_LOW = 16'hFFFF;
    localparam logic [15:0] MASK_FUNC_HIGH = 16'h0155;
    localparam logic [15:0] MASK_FUNC_LOW_UPPER = 16'h5500;

    // function-select bit positions
    localparam int unsigned POS_PIN20_FUNC = 8;
    localparam int unsigned POS_PIN19_FUNC = 6;
    localparam int unsigned POS_PIN18_FUNC = 4;
    localparam int unsigned POS_PIN17_FUNC = 2;
    localparam int unsigned POS_PIN16_FUNC = 0;
    localparam int unsigned POS_PIN15_FUNC = 14;
    localparam int unsigned POS_PIN14_FUNC = 12;
    localparam int unsigned POS_PIN13_FUNC = 10;
    localparam int unsigned POS_PIN12_FUNC = 8;

    // pins of the direction-high register start here
    localparam int unsigned DIR_HIGH_BASE_PIN = 16;
    localparam int unsigned DIR_HIGH_PINS = 5;

    typedef struct packed {
        logic wake_on_lan_output;
        logic external_output;
        logic mdc;
        logic mdio_out;
        logic mdio_oe;
        logic tx_en;
    } pcpm_emac_out_s;

    typedef struct packed {
        logic link_status_input;
        logic mdio_in;
        logic crs;
        logic col;
        logic tx_clk;
    } pcpm_emac_in_s;

    typedef struct packed {
        logic [20:0] value;
        logic [20:0] oe;
    } pcpm_pad_drive_s;

endpackage

// ==== test/pcpm_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcpm_far_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [20:0] pad_out,
    input wire logic [20:0] pad_oe,
    input wire logic [20:0] ext_level,
    output logic [20:0] pad_in,
    output pcpm_pkg::pcpm_emac_out_s emac_out
);
    // controller outputs step through every pattern so a swapped route shows
    always_ff @(posedge sys_clk) begin
        if (rst)
            emac_out <= '0;
        else
            emac_out <= pcpm_pkg::pcpm_emac_out_s'(emac_out + 6'h01);
    end
    // a driven pad reads its own level, an undriven one the outside world
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule
`default_nettype wire

// ==== test/pcpm_port_c_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcpm_port_c_monitor #(
    parameter int unsigned PINS = 21
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic [PINS-1:0] port_out_value,
    input wire logic [PINS-1:0] port_in_value,
    input wire pcpm_pkg::pcpm_emac_out_s emac_out,
    input wire pcpm_pkg::pcpm_emac_in_s emac_in,
    input wire logic [PINS-1:0] pad_in,
    input wire logic [PINS-1:0] pad_out,
    input wire logic [PINS-1:0] pad_oe
);
    logic [2:0] rq;
    logic [15:0] fh;
    logic [15:0] fl;
    logic [20:0] dr;
    // mirror of the stored registers; rq masks the sync chain refill
    always_ff @(posedge sys_clk) begin
        rq <= {rq[1:0], rst};
        if (rst) begin
            {fh, fl, dr} <= '0;
        end else if (reg_write) begin
            case (reg_addr)
                pcpm_pkg::OFS_DIR_HIGH: dr[20:16] <= reg_wdata[4:0];
                pcpm_pkg::OFS_DIR_LOW: dr[15:0] <= reg_wdata;
                pcpm_pkg::OFS_FUNC_HIGH: fh <= reg_wdata & pcpm_pkg::MASK_FUNC_HIGH;
                pcpm_pkg::OFS_FUNC_LOW_UPPER: fl <= reg_wdata & pcpm_pkg::MASK_FUNC_LOW_UPPER;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst || (|rq));
    a_rdata_idle: assert property (!reg_read |=> reg_rdata == 16'h0000)
        else $error("read data not cleared");
    a_rdlow_value: assert property (reg_read && reg_addr == pcpm_pkg::OFS_DIR_LOW
        |=> reg_rdata == $past(dr[15:0])) else $error("low direction readback");
    a_dirh_reserved: assert property (reg_read && reg_addr == pcpm_pkg::OFS_DIR_HIGH
        |=> reg_rdata[15:5] == 11'h000) else $error("direction reserved bits");
    a_func_reserved: assert property (reg_read && reg_addr == pcpm_pkg::OFS_FUNC_HIGH
        |=> (reg_rdata & ~pcpm_pkg::MASK_FUNC_HIGH) == 16'h0000) else $error("function reserved");
    a_general_pins: assert property (pad_oe[11:0] == $past(dr[11:0]) &&
        (pad_out[11:0] & pad_oe[11:0]) == ($past(port_out_value[11:0]) & pad_oe[11:0]))
        else $error("general pin drive");
    a_wol_pin: assert property ($past(fh[8]) |-> pad_oe[20] &&
        pad_out[20] == $past(emac_out.wake_on_lan_output)) else $error("pin 20 routing");
    a_mdio_pin: assert property ($past(fh[0]) |-> pad_oe[16] == $past(emac_out.mdio_oe) &&
        pad_out[16] == $past(emac_out.mdio_out)) else $error("pin 16 routing");
    a_txen_pin: assert property ($past(fl[8]) |-> pad_oe[12] &&
        pad_out[12] == $past(emac_out.tx_en)) else $error("pin 12 routing");
    a_lnk_input: assert property ($past(fh[4]) |-> !pad_oe[18])
        else $error("pin 18 driven");
    a_sync_lag: assert property (port_in_value == $past(pad_in, 3))
        else $error("input sync lag");
    a_mdio_input: assert property (emac_in.mdio_in == ($past(fh[0]) & $past(pad_in[16], 3)))
        else $error("pin 16 input routing");
endmodule
bind pcpm_port_c pcpm_port_c_monitor #(.PINS(PINS)) pcpm_port_c_monitor_i (.sys_clk, .rst,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .port_out_value,
    .port_in_value, .emac_out, .emac_in, .pad_in, .pad_out, .pad_oe);
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] reg_rdata;
    logic [20:0] port_out_value = 21'h000000;
    logic [20:0] ext_level = 21'h000000;
    logic [20:0] port_in_value, pad_in, pad_out, pad_oe, oe_x;
    logic [15:0] mask_tab [5];
    pcpm_pkg::pcpm_emac_out_s emac_out;
    pcpm_pkg::pcpm_emac_in_s emac_in;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    always #5 sys_clk = ~sys_clk;
    pcpm_port_c pcpm_port_c_i (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .port_out_value, .port_in_value, .emac_out, .emac_in, .pad_in, .pad_out,
        .pad_oe);
    pcpm_far_model pcpm_far_model_i (.sys_clk, .rst, .pad_out, .pad_oe, .ext_level, .pad_in,
        .emac_out);
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 chk(21'(reg_rdata), 21'(exp));
    endtask
    task automatic complete_run;
        $display("mismatches %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // the whole sequence needs well under 400 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            $display("ERROR at %0t: timeout", $time);
            complete_run();
        end
    end
    initial begin
        mask_tab = '{pcpm_pkg::MASK_DIR_HIGH, pcpm_pkg::MASK_DIR_LOW, pcpm_pkg::MASK_FUNC_HIGH,
            pcpm_pkg::MASK_FUNC_LOW_UPPER, 16'h0000};
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        for (int a = 0; a < 10; a += 2) rd(4'(a), 16'h0000);
        $display("reset values done");
        for (int a = 0; a < 10; a += 2) wr(4'(a), 16'hFFFF);
        for (int a = 0; a < 10; a += 2) rd(4'(a), mask_tab[a/2]);
        $display("register access done");
        wr(pcpm_pkg::OFS_FUNC_HIGH, 16'h0000);
        wr(pcpm_pkg::OFS_FUNC_LOW_UPPER, 16'h0000);
        wr(pcpm_pkg::OFS_DIR_LOW, 16'hA5A5);
        wr(pcpm_pkg::OFS_DIR_HIGH, 16'h0015);
        port_out_value <= 21'h0F0F0F;
        ext_level <= 21'h1CC333;
        oe_x = 21'h15A5A5;
        repeat (5) @(posedge sys_clk);
        #1 chk(pad_oe, oe_x);
        chk(pad_out & oe_x, 21'h0F0F0F & oe_x);
        chk(port_in_value, (21'h0F0F0F & oe_x) | (21'h1CC333 & ~oe_x));
        $display("direction done");
        wr(pcpm_pkg::OFS_DIR_LOW, 16'hFFFF);
        wr(pcpm_pkg::OFS_DIR_HIGH, 16'h001F);
        wr(pcpm_pkg::OFS_FUNC_HIGH, pcpm_pkg::MASK_FUNC_HIGH);
        wr(pcpm_pkg::OFS_FUNC_LOW_UPPER, pcpm_pkg::MASK_FUNC_LOW_UPPER);
        ext_level <= 21'h1FFFFF;
        repeat (5) @(posedge sys_clk);
        #1 chk(pad_oe & 21'h1EFFFF, 21'h1A1FFF);
        chk(21'({emac_in.link_status_input, emac_in.crs, emac_in.col, emac_in.tx_clk}),
            21'h00000F);
        wr(pcpm_pkg::OFS_FUNC_HIGH, 16'h0000);
        wr(pcpm_pkg::OFS_FUNC_LOW_UPPER, 16'h0000);
        repeat (5) @(posedge sys_clk);
        #1 chk(21'({emac_in.link_status_input, emac_in.mdio_in, emac_in.crs, emac_in.col,
            emac_in.tx_clk}), 21'h000000);
        chk(pad_oe, 21'h1FFFFF);
        $display("function select done");
        complete_run();
    end
endmodule
`default_nettype wire
